// ==== src/cpk_core.sv ====
/*
  Core control logic: timer/prescaler configuration, oscillator trim,
  program counter sequencing, two-level return stack, indirect pointer
  and the basic pin port (direction, pull-up, wake-on-change, reads).
  Assumes an instruction decoder that presents one operation per clock
  as strobes with operand data, and a data memory outside that takes the
  indirect address this block produces. All inputs are synchronous.
*/
// How it works
// R1: Configuration register is 8-bit write-only, loaded by its instruction, reset all ones.
// R2: Output-direction pins lose pull-up and wake-up whatever the configuration says.
// R3: External timer clock source forces the timer clock pin to input.
// R4: Configuration bit 7 low enables wake-up on pin change for the group.
// R5: Configuration bit 6 low enables weak pull-ups for the group, no per-pin choice.
// R6: Configuration bit 5 selects external pin transitions or instruction clock for timer.
// R7: Configuration bit 4 one counts falling edges, zero rising edges.
// R8: Configuration bit 3 gives the prescaler to watchdog when one, timer when zero.
// R9: Rate field n gives timer 1:2^(n+1) and watchdog 1:2^n.
// R10: Trim is seven-bit signed in bits 7..1, bit 0 reads zero, resets ones.
// R11: Counter increments every cycle unless an instruction loads it.
// R12: Jump takes bits 8..0 from instruction and bit 9 from page select.
// R13: Call or low-byte write loads bits 7..0 and clears bit 8.
// R14: Low-byte register is counter bits 7..0; upper bits not directly accessible.
// R15: Reset sets counter all ones; it then rolls over to zero.
// R16: Reset clears page select so jumps go to page 0.
// R17: Two 12-bit levels; call moves level 1 to 2, writes counter plus one.
// R18: Return loads counter from level 1, level 2 copies down, literal to W.
// R19: Overflow keeps two newest addresses; no overflow or underflow flag.
// R20: Indirect access uses pointer; self read gives 00h, self write changes nothing.
// R21: Pointer low five bits pick location; bank bits per variant, unused bits read one.
// R22: Port read returns pin levels; reset makes every pin an input.
// R23: Port bits 7..6 and alternate-function pins read zero; master clear pin has pull-up.
// R24: Direction register is write-only, loaded by instruction, one is high impedance.
// R25: Wake detector compares enabled pins to last port read while asleep.
`timescale 1ns/1ps
`default_nettype none

module cpk_core #(
  parameter bit LARGE = 1'b1 // One selects the four-bank, four-pin-group variant
) (
  input wire logic i_clk,
  input wire logic i_rst,
  // Decoder strobes and operands
  input wire logic [7:0] i_w,
  input wire logic i_cfg_load,
  input wire logic i_dir_load,
  input wire logic i_trim_wr,
  input wire logic i_ptr_wr,
  input wire logic i_port_wr,
  input wire logic i_port_rd,
  input wire cpk_pkg::cpk_op_type i_op,
  input wire logic [8:0] i_instr_addr,
  input wire logic [7:0] i_pcl_data,
  input wire logic [7:0] i_lit,
  input wire logic [7:0] i_status,
  input wire logic i_indirect_wr,
  input wire logic [7:0] i_mem_rdata,
  input wire logic i_sleep,
  input wire logic i_master_clear_pin_en,
  input wire logic [5:0] i_alt_fn,
  input wire logic [5:0] i_pin,
  // Counter, stack and working register load
  output logic [9:0] o_pc,
  output logic [7:0] o_pc_low_byte,
  output logic [7:0] o_w_load_data,
  output logic o_w_load,
  // Configuration and trim views
  output logic [7:0] o_timer_prescale_config,
  output logic o_timer_clock_source_sel,
  output logic o_timer_edge_sel,
  output logic o_prescaler_assign,
  output logic [8:0] o_timer_ratio,
  output logic [7:0] o_wdt_ratio,
  output logic [7:0] o_osc_trim,
  // Indirect addressing
  output logic [7:0] o_indirect_pointer,
  output logic [6:0] o_ind_addr,
  output logic o_ind_wr,
  output logic [7:0] o_ind_rdata,
  // Pins
  output logic [7:0] o_pin_io_port,
  output logic [5:0] o_pin_out,
  output logic [5:0] o_pin_oe_n,
  output logic [5:0] o_pullup_on,
  output logic o_wake
);

  localparam logic [5:0] GROUP = LARGE ? cpk_pkg::PULL_WAKE_MASK_LARGE : cpk_pkg::PULL_WAKE_MASK_SMALL;
  localparam int TPIN = LARGE ? cpk_pkg::TIMER_PIN_LARGE : cpk_pkg::TIMER_PIN_SMALL;
  localparam logic [9:0] PC_TOP = '1; // Last program word, where the trim load sits
  localparam logic [7:0] PTR_FILL = LARGE ? cpk_pkg::PTR_LARGE_FILL : cpk_pkg::PTR_SMALL_FILL;

  // Elaboration checks; the slices below are written for these package widths
  if (cpk_pkg::PC_W != 10) begin : g_pc_width_check
    $error("cpk_core needs a ten-bit program counter");
  end
  if (cpk_pkg::STK_W != cpk_pkg::PC_W + 2) begin : g_stack_width_check
    $error("cpk_core needs stack levels two bits wider than the counter");
  end
  if (cpk_pkg::PTR_LOC_W != 5 || TPIN >= cpk_pkg::PORT_W) begin : g_layout_check
    $error("cpk_core pointer or pin layout out of range");
  end

  logic [7:0] cfg_reg;
  logic [6:0] trim_reg;
  logic [9:0] pc_reg;
  logic [9:0] pc_next;
  logic [11:0] stk1_reg;
  logic [11:0] stk2_reg;
  logic [7:0] ptr_reg;
  logic [5:0] dir_reg;
  logic [5:0] latch_reg;
  logic [5:0] snap_reg;
  logic [5:0] eff_dir;
  logic [5:0] pull_en;
  logic [5:0] wake_en;
  logic [5:0] pin_view;
  logic [7:0] ptr_view;
  logic self_ind;

  // Pointer view with unimplemented bits forced to one per variant
  function automatic logic [7:0] ptr_read(input logic [7:0] p);
    ptr_read = LARGE ? (p | cpk_pkg::PTR_LARGE_FILL) : (p | cpk_pkg::PTR_SMALL_FILL); // [R21]
  endfunction

  // Counter plus one; wraps from the last word to zero with no carry kept
  function automatic logic [9:0] pc_inc(input logic [9:0] p);
    pc_inc = p + 10'h001; // [R11] [R15]
  endfunction

  // Configuration register: only its own instruction writes it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= cpk_pkg::CFG_RESET; // [R1]
    end else if (i_cfg_load) begin
      cfg_reg <= i_w; // [R1]
    end
  end

  // Oscillator trim; written once by start-up code and then left alone
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trim_reg <= cpk_pkg::TRIM_RESET; // [R10]
    end else if (i_trim_wr) begin
      trim_reg <= i_w[7:1]; // [R10]
    end
  end

  // Next counter value; operations are mutually exclusive per cycle
  always_comb begin
    pc_next = pc_inc(pc_reg); // [R11] [R15]
    case (i_op)
      cpk_pkg::CPK_OP_JUMP: pc_next = {i_status[cpk_pkg::STATUS_PAGE_BIT], i_instr_addr}; // [R12] [R16]
      cpk_pkg::CPK_OP_CALL: pc_next = {pc_reg[9], 1'b0, i_instr_addr[7:0]}; // [R13]
      cpk_pkg::CPK_OP_PCLWR: pc_next = {pc_reg[9], 1'b0, i_pcl_data}; // [R13] [R14]
      cpk_pkg::CPK_OP_RETLIT: pc_next = stk1_reg[9:0]; // [R18]
      default: pc_next = pc_inc(pc_reg);
    endcase
  end

  // Program counter; reset points at the last word so the trim load runs first
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pc_reg <= PC_TOP; // [R15]
    end else begin
      pc_reg <= pc_next; // [R11]
    end
  end

  // Return stack; the oldest entry just falls off, nothing reports it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stk1_reg <= 12'h000;
      stk2_reg <= 12'h000;
    end else if (i_op == cpk_pkg::CPK_OP_CALL) begin
      stk2_reg <= stk1_reg; // [R17] [R19]
      stk1_reg <= {2'b00, pc_inc(pc_reg)}; // [R17]
    end else if (i_op == cpk_pkg::CPK_OP_RETLIT) begin
      stk1_reg <= stk2_reg; // [R18] level 2 keeps its value
    end
  end

  // Working register load strobe; one cycle for each return
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_w_load <= 1'b0;
    end else begin
      o_w_load <= (i_op == cpk_pkg::CPK_OP_RETLIT); // [R18]
    end
  end

  // Literal of a return; follows the input every cycle, meaningful only with the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_w_load_data <= 8'h00;
    end else begin
      o_w_load_data <= i_lit; // [R18]
    end
  end

  // Indirect pointer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_reg <= 8'h00;
    end else if (i_ptr_wr) begin
      ptr_reg <= i_w;
    end
  end

  assign ptr_view = ptr_read(ptr_reg);
  assign self_ind = (ptr_reg[cpk_pkg::PTR_LOC_W-1:0] == 5'h00);

  // Indirect address; the small part has no bank bit 6
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ind_addr <= 7'h00;
    end else begin
      o_ind_addr <= LARGE ? ptr_reg[6:0] : {1'b0, ptr_reg[5:0]}; // [R21]
    end
  end

  // Indirect write strobe; a write aimed at the access register itself is dropped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ind_wr <= 1'b0;
    end else begin
      o_ind_wr <= i_indirect_wr && !self_ind; // [R20]
    end
  end

  // Indirect read data; location zero of a bank is the access register and reads 00h
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ind_rdata <= 8'h00;
    end else begin
      o_ind_rdata <= self_ind ? 8'h00 : i_mem_rdata; // [R20]
    end
  end

  // Direction latches; write-only, so nothing reads them back
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir_reg <= 6'h3F; // [R22] [R24]
    end else if (i_dir_load) begin
      dir_reg <= i_w[5:0]; // [R24]
    end
  end

  // Output data latches; they keep their value while the pin is an input
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_reg <= 6'h00;
    end else if (i_port_wr) begin
      latch_reg <= i_w[5:0];
    end
  end

  // Effective direction: input-only pin always forced to input, timer clock pin only while the external source is selected
  always_comb begin
    eff_dir = dir_reg;
    eff_dir[cpk_pkg::INPUT_ONLY_PIN] = 1'b1;
    if (cfg_reg[cpk_pkg::CFG_TSRC]) begin
      eff_dir[TPIN] = 1'b1; // [R3] [R6]
    end
  end

  // Pull-up and wake enables; an output pin gets neither
  always_comb begin
    pull_en = {6{~cfg_reg[cpk_pkg::CFG_PULL_N]}} & GROUP & eff_dir; // [R5] [R2]
    wake_en = {6{~cfg_reg[cpk_pkg::CFG_WAKE_N]}} & GROUP & eff_dir; // [R4] [R2]
    if (i_master_clear_pin_en) begin
      pull_en[cpk_pkg::INPUT_ONLY_PIN] = 1'b1; // [R23]
      wake_en[cpk_pkg::INPUT_ONLY_PIN] = 1'b0; // [R23]
    end
  end

  // Reads show the pins, never the latches
  assign pin_view = i_pin & ~i_alt_fn; // [R22] [R23]

  // Snapshot at each port read is the wake reference
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      snap_reg <= 6'h00;
    end else if (i_port_rd) begin
      snap_reg <= pin_view; // [R25]
    end
  end

  // Pin drivers; an input pin keeps its latch, so a later turn to output shows it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= 6'h00;
      o_pin_oe_n <= 6'h3F; // [R22]
    end else begin
      o_pin_out <= latch_reg;
      o_pin_oe_n <= eff_dir; // [R24]
    end
  end

  // Weak pull-ups
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pullup_on <= 6'h00;
    end else begin
      o_pullup_on <= pull_en; // [R5]
    end
  end

  // Wake flag; recomputed every cycle, so it drops once the pins match the snapshot again or sleep ends
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= i_sleep && |((pin_view ^ snap_reg) & wake_en); // [R25]
    end
  end

  // Port read value; the latches never show here, only the pins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_io_port <= 8'h00;
    end else begin
      o_pin_io_port <= {2'b00, pin_view}; // [R22] [R23]
    end
  end

  // Timer prescale ratio as a division factor
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer_ratio <= 9'h000;
    end else begin
      o_timer_ratio <= 9'h002 << cfg_reg[cpk_pkg::CFG_RATE_HI:0]; // [R9]
    end
  end

  // Watchdog prescale ratio as a division factor
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wdt_ratio <= 8'h00;
    end else begin
      o_wdt_ratio <= 8'h01 << cfg_reg[cpk_pkg::CFG_RATE_HI:0]; // [R9]
    end
  end

  // Counter views; o_pc takes the same next value as the counter, so the two never part
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pc <= PC_TOP; // [R15]
      o_pc_low_byte <= PC_TOP[7:0];
    end else begin
      o_pc <= pc_next;
      o_pc_low_byte <= pc_next[7:0]; // [R14]
    end
  end

  // Configuration views; a second register stage, so they trail a load by two edges
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer_prescale_config <= cpk_pkg::CFG_RESET; // [R1]
      o_timer_clock_source_sel <= cpk_pkg::CFG_RESET[cpk_pkg::CFG_TSRC];
      o_timer_edge_sel <= cpk_pkg::CFG_RESET[cpk_pkg::CFG_TEDGE];
      o_prescaler_assign <= cpk_pkg::CFG_RESET[cpk_pkg::CFG_PSA];
    end else begin
      o_timer_prescale_config <= cfg_reg;
      o_timer_clock_source_sel <= cfg_reg[cpk_pkg::CFG_TSRC]; // [R6]
      o_timer_edge_sel <= cfg_reg[cpk_pkg::CFG_TEDGE]; // [R7]
      o_prescaler_assign <= cfg_reg[cpk_pkg::CFG_PSA]; // [R8]
    end
  end

  // Trim view; bit 0 is unimplemented and reads zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_osc_trim <= {cpk_pkg::TRIM_RESET, 1'b0}; // [R10]
    end else begin
      o_osc_trim <= {trim_reg, 1'b0}; // [R10]
    end
  end

  // Pointer view; the unused bits read one even while reset holds
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_indirect_pointer <= PTR_FILL; // [R21]
    end else begin
      o_indirect_pointer <= ptr_view; // [R21]
    end
  end

endmodule

`default_nettype wire

// ==== src/cpk_pkg.sv ====
/*
  Package for the core control block: register reset values, field
  positions, program counter and stack widths, pointer layout and the
  operation codes that the decoder hands to the core.
  Assumes one clock, the instruction cycle clock, shared by everything.
*/
package cpk_pkg;
  // Widths
  localparam int PC_W = 10;
  localparam int STK_W = 12;
  localparam int DATA_W = 8;
  localparam int PORT_W = 6;

  // Timer and prescaler configuration fields
  localparam int CFG_WAKE_N = 7;
  localparam int CFG_PULL_N = 6;
  localparam int CFG_TSRC = 5;
  localparam int CFG_TEDGE = 4;
  localparam int CFG_PSA = 3;
  localparam int CFG_RATE_HI = 2;
  localparam logic [7:0] CFG_RESET = 8'hFF;

  // Oscillator trim: bits 7..1 hold the trim, bit 0 reads zero
  localparam logic [6:0] TRIM_RESET = 7'h7F;

  // Status bit that feeds counter bit 9
  localparam int STATUS_PAGE_BIT = 5;

  // Pointer layout
  localparam int PTR_LOC_W = 5;
  localparam logic [7:0] PTR_SMALL_FILL = 8'hC0;
  localparam logic [7:0] PTR_LARGE_FILL = 8'h80;

  // Pins with pull-up and wake-up; the external timer clock pin
  localparam logic [5:0] PULL_WAKE_MASK_SMALL = 6'h0B;
  localparam logic [5:0] PULL_WAKE_MASK_LARGE = 6'h1B;
  localparam int INPUT_ONLY_PIN = 3;
  localparam int TIMER_PIN_SMALL = 2;
  localparam int TIMER_PIN_LARGE = 5;

  // Control-transfer operations presented by the decoder
  typedef enum logic [2:0] {
    CPK_OP_NONE = 3'b000,
    CPK_OP_JUMP = 3'b001,
    CPK_OP_CALL = 3'b010,
    CPK_OP_RETLIT = 3'b011,
    CPK_OP_PCLWR = 3'b100
  } cpk_op_type;
endpackage

// ==== verif/cpk_core_assertions.sv ====
/* Port checker for cpk_core.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module cpk_core_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_w,
  input wire logic i_cfg_load,
  input wire cpk_pkg::cpk_op_type i_op,
  input wire logic [8:0] i_instr_addr,
  input wire logic [7:0] i_lit,
  input wire logic [7:0] i_status,
  input wire logic i_ptr_wr,
  input wire logic i_indirect_wr,
  input wire logic i_sleep,
  input wire logic [5:0] i_alt_fn,
  input wire logic [9:0] o_pc,
  input wire logic [7:0] o_w_load_data,
  input wire logic o_w_load,
  input wire logic [7:0] o_timer_prescale_config,
  input wire logic [8:0] o_timer_ratio,
  input wire logic [7:0] o_indirect_pointer,
  input wire logic o_ind_wr,
  input wire logic [7:0] o_pin_io_port,
  input wire logic o_wake
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // Config views and ratios show two edges on; the other requests one edge on
  a_cfg_load_takes: assert property
    (i_cfg_load |-> ##2 o_timer_prescale_config == $past(i_w, 2)) else $error("config load lost");
  a_ratio_from_rate: assert property
    (i_cfg_load ##1 !i_cfg_load |=> o_timer_ratio == (9'h002 << $past(i_w[2:0], 2))) else $error("bad ratio");
  a_pc_plus_one: assert property
    (i_op == cpk_pkg::CPK_OP_NONE |=> o_pc == $past(o_pc) + 10'h001) else $error("pc not incremented");
  a_jump_target: assert property
    (i_op == cpk_pkg::CPK_OP_JUMP |=> o_pc == {$past(i_status[5]), $past(i_instr_addr)}) else $error("bad jump");
  a_call_target: assert property
    (i_op == cpk_pkg::CPK_OP_CALL |=> o_pc == {$past(o_pc[9]), 1'b0, $past(i_instr_addr[7:0])}) else $error("bad call");
  a_return_literal: assert property
    (i_op == cpk_pkg::CPK_OP_RETLIT |=> o_w_load && o_w_load_data == $past(i_lit)) else $error("bad literal");
  // Pointer settled for a cycle, so the self check sees the live value
  a_self_write_void: assert property
    (i_indirect_wr && !i_ptr_wr && !$past(i_ptr_wr) && o_indirect_pointer[4:0] == 5'h00 |=> !o_ind_wr)
    else $error("self write not void");
  a_port_read_zeros: assert property
    (1'b1 |=> o_pin_io_port[7:6] == 2'b00 && (o_pin_io_port[5:0] & $past(i_alt_fn)) == 6'h00) else $error("bad port bits");
  a_wake_sleep_only: assert property
    (!i_sleep |=> !o_wake) else $error("wake while awake");
  c_call: cover property (i_op == cpk_pkg::CPK_OP_CALL);
  c_self_wr: cover property (i_indirect_wr && o_indirect_pointer[4:0] == 5'h00);
  c_wake: cover property (o_wake);
endmodule
bind cpk_core cpk_core_assertions cpk_core_assertions_inst (.i_clk, .i_rst, .i_w, .i_cfg_load, .i_op,
  .i_instr_addr, .i_lit, .i_status, .i_ptr_wr, .i_indirect_wr, .i_sleep, .i_alt_fn, .o_pc, .o_w_load_data,
  .o_w_load, .o_timer_prescale_config, .o_timer_ratio, .o_indirect_pointer, .o_ind_wr, .o_pin_io_port, .o_wake);
`default_nettype wire

// ==== verif/cpk_core_test.sv ====
/* Self-checking bench for cpk_core, large variant.
   Assumes the checker binds itself; one 20 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module cpk_core_test;
  logic i_clk = 1'b0, i_rst = 1'b1, i_cfg_load = 1'b0, i_dir_load = 1'b0, i_trim_wr = 1'b0, i_ptr_wr = 1'b0;
  logic i_port_wr = 1'b0, i_port_rd = 1'b0, i_indirect_wr = 1'b0, i_sleep = 1'b0, i_master_clear_pin_en = 1'b0;
  logic [7:0] i_w = 8'h00, i_pcl_data = 8'h00, i_lit = 8'h00, i_status = 8'h00, i_mem_rdata = 8'h00;
  logic [8:0] i_instr_addr = 9'h000;
  logic [5:0] i_alt_fn = 6'h00, i_pin = 6'h00;
  cpk_pkg::cpk_op_type i_op = cpk_pkg::CPK_OP_NONE;
  logic [9:0] o_pc;
  logic [8:0] o_timer_ratio;
  logic [7:0] o_pc_low_byte, o_w_load_data, o_timer_prescale_config, o_wdt_ratio, o_osc_trim;
  logic [7:0] o_indirect_pointer, o_ind_rdata, o_pin_io_port;
  logic [6:0] o_ind_addr;
  logic [5:0] o_pin_out, o_pin_oe_n, o_pullup_on;
  logic o_w_load, o_timer_clock_source_sel, o_timer_edge_sel, o_prescaler_assign, o_ind_wr, o_wake;
  int err_count = 0, checks = 0;
  cpk_core #(.LARGE(1'b1)) cpk_core_inst (.i_clk, .i_rst, .i_w, .i_cfg_load, .i_dir_load, .i_trim_wr,
    .i_ptr_wr, .i_port_wr, .i_port_rd, .i_op, .i_instr_addr, .i_pcl_data, .i_lit, .i_status, .i_indirect_wr,
    .i_mem_rdata, .i_sleep, .i_master_clear_pin_en, .i_alt_fn, .i_pin, .o_pc, .o_pc_low_byte, .o_w_load_data, .o_w_load,
    .o_timer_prescale_config, .o_timer_clock_source_sel, .o_timer_edge_sel, .o_prescaler_assign,
    .o_timer_ratio, .o_wdt_ratio, .o_osc_trim, .o_indirect_pointer, .o_ind_addr, .o_ind_wr, .o_ind_rdata,
    .o_pin_io_port, .o_pin_out, .o_pin_oe_n, .o_pullup_on, .o_wake);
  // 50 ns period
  always #25 i_clk = ~i_clk;
  // Case inequality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset;
    cyc(20);
    chk(o_pc, 10'h3FF);
    chk(o_timer_prescale_config, 8'hFF);
    chk(o_osc_trim, 8'hFE);
    chk(o_pin_oe_n, 6'h3F);
    chk(o_indirect_pointer, 8'h80);
    i_rst = 1'b0;
    cyc();
    chk(o_pc, 10'h000);
    $display("reset test done");
  endtask
  // Every rate code, with the flag bits toggled from code to code
  task automatic t_cfg;
    for (int n = 0; n < 8; n++) begin
      i_w = {n[0], n[1], n[2], ~n[0], n[1], n[2:0]};
      i_cfg_load = 1'b1;
      cyc();
      i_cfg_load = 1'b0;
      cyc();
      chk(o_timer_prescale_config, i_w);
      chk({o_timer_clock_source_sel, o_timer_edge_sel, o_prescaler_assign}, i_w[5:3]);
      chk(o_timer_ratio, 9'h002 << n);
      chk(o_wdt_ratio, 8'h01 << n);
    end
    $display("config test done");
  endtask
  task automatic t_pins;
    i_w = 8'h0F;
    i_cfg_load = 1'b1;
    i_trim_wr = 1'b1;
    cyc();
    i_cfg_load = 1'b0;
    i_trim_wr = 1'b0;
    i_w = 8'h1E;
    i_dir_load = 1'b1;
    i_port_wr = 1'b1;
    cyc();
    i_dir_load = 1'b0;
    i_port_wr = 1'b0;
    cyc(2);
    chk(o_osc_trim, 8'h0E);
    chk(o_pin_oe_n, 6'h1E);
    chk(o_pin_out, 6'h1E);
    chk(o_pullup_on, 6'h1A);
    // External clock and pull-ups off; master clear keeps its own pull-up
    i_w = 8'h6F;
    i_master_clear_pin_en = 1'b1;
    i_cfg_load = 1'b1;
    cyc();
    i_cfg_load = 1'b0;
    cyc(2);
    chk(o_pin_oe_n, 6'h3E);
    chk(o_pullup_on, 6'h08);
    $display("pin test done");
  endtask
  task automatic t_port;
    i_master_clear_pin_en = 1'b0;
    i_w = 8'h3F;
    i_dir_load = 1'b1;
    i_pin = 6'h2D;
    i_alt_fn = 6'h20;
    cyc();
    i_dir_load = 1'b0;
    i_w = 8'h4F;
    i_cfg_load = 1'b1;
    cyc();
    i_cfg_load = 1'b0;
    i_port_rd = 1'b1;
    cyc();
    i_port_rd = 1'b0;
    cyc();
    chk(o_pin_io_port, 8'h0D);
    chk(o_wake, 1'b0);
    i_sleep = 1'b1;
    i_pin = 6'h2F;
    cyc(2);
    chk(o_wake, 1'b1);
    i_sleep = 1'b0;
    $display("port test done");
  endtask
  task automatic t_ind;
    i_w = 8'h27;
    i_ptr_wr = 1'b1;
    i_mem_rdata = 8'h3C;
    cyc();
    i_ptr_wr = 1'b0;
    i_indirect_wr = 1'b1;
    cyc();
    i_indirect_wr = 1'b0;
    chk(o_ind_wr, 1'b1);
    chk(o_indirect_pointer, 8'hA7);
    chk(o_ind_addr, 7'h27);
    chk(o_ind_rdata, 8'h3C);
    i_w = 8'h40;
    i_ptr_wr = 1'b1;
    cyc();
    i_ptr_wr = 1'b0;
    cyc();
    i_indirect_wr = 1'b1;
    cyc();
    i_indirect_wr = 1'b0;
    chk(o_ind_wr, 1'b0);
    chk(o_ind_rdata, 8'h00);
    chk(o_indirect_pointer, 8'hC0);
    $display("indirect test done");
  endtask
  // One operation per edge; ops run back to back, so i_op is not cleared here
  task automatic op(input cpk_pkg::cpk_op_type o, input logic [8:0] a, input logic [9:0] exp);
    i_op = o;
    i_instr_addr = a;
    i_lit = a[7:0];
    i_pcl_data = a[7:0];
    cyc();
    chk(o_pc, exp);
    chk(o_pc_low_byte, exp[7:0]);
  endtask
  task automatic t_pc;
    i_status = 8'h20;
    op(cpk_pkg::CPK_OP_JUMP, 9'h1F0, 10'h3F0);
    i_status = 8'h00;
    op(cpk_pkg::CPK_OP_CALL, 9'h012, 10'h212);
    op(cpk_pkg::CPK_OP_PCLWR, 9'h077, 10'h277);
    op(cpk_pkg::CPK_OP_CALL, 9'h045, 10'h245);
    op(cpk_pkg::CPK_OP_CALL, 9'h080, 10'h280);
    op(cpk_pkg::CPK_OP_RETLIT, 9'h05A, 10'h246);
    chk({o_w_load, o_w_load_data}, 9'h15A);
    op(cpk_pkg::CPK_OP_RETLIT, 9'h05B, 10'h278);
    op(cpk_pkg::CPK_OP_RETLIT, 9'h05C, 10'h278);
    op(cpk_pkg::CPK_OP_NONE, 9'h000, 10'h279);
    $display("counter test done");
  endtask
  initial begin
    t_reset();
    t_cfg();
    t_pins();
    t_port();
    t_ind();
    t_pc();
    finish_test();
  end
  // Tests take about 64 cycles; give them about thirty times that
  initial begin
    #(50 * 2000);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
